/* pkg/rwa_defs.svh */
`ifndef RWA_DEFS_SVH
`define RWA_DEFS_SVH

// Datapath geometry: one received word, and three words of history for a 32-bit pattern.
`define RWA_WORD_W        20
`define RWA_HIST_W        60
`define RWA_OFF_MAX       5'h13

// Register byte offsets on the APB slave.
`define RWA_CTRL_OFF      8'h00
`define RWA_PAT_OFF       8'h04
`define RWA_SMCFG_OFF     8'h08
`define RWA_RLCFG_OFF     8'h0C
`define RWA_STATUS_OFF    8'h10
`define RWA_ISTAT_OFF     8'h14
`define RWA_IMASK_OFF     8'h18

// Control register field positions.
`define RWA_MODE_LSB      0
`define RWA_WIDTH_LSB     2
`define RWA_PLEN_LSB      4
`define RWA_ENC_BIT       7
`define RWA_RLEN_BIT      8
`define RWA_ALIGN_BIT     9
`define RWA_SLIP_BIT      10

// Sync machine configuration field positions, each field holds count minus one.
`define RWA_GOOD_LSB      0
`define RWA_BAD_LSB       8
`define RWA_NPAT_LSB      16

// Interrupt status and mask bit positions.
`define RWA_IRQ_PAT       0
`define RWA_IRQ_SYNC      1
`define RWA_IRQ_LOSS      2
`define RWA_IRQ_RLV       3
`define RWA_IRQ_CFG       4

// Encodings of mode, interface width and pattern length.
`define RWA_MODE_MANUAL   2'h0
`define RWA_MODE_SLIP     2'h1
`define RWA_MODE_SM       2'h2
`define RWA_WID_8         2'h0
`define RWA_WID_10        2'h1
`define RWA_WID_16        2'h2
`define RWA_WID_20        2'h3
`define RWA_PLEN_7        3'h0
`define RWA_PLEN_8        3'h1
`define RWA_PLEN_10       3'h2
`define RWA_PLEN_16       3'h3
`define RWA_PLEN_20       3'h4
`define RWA_PLEN_32       3'h5

// Reset values.
`define RWA_CTRL_RST      32'h0000_00AC
`define RWA_PAT_RST       32'h0000_017C
`define RWA_SMCFG_RST     32'h0002_0303
`define RWA_RLCFG_RST     32'h0000_0028

`endif

/* pkg/rwa_pkg.sv */
package rwa_pkg;

	// States of the automatic synchronization machine.
	typedef enum logic [1:0] {
		ST_LOSS,
		ST_ACQ,
		ST_SYNC
	} rwa_sync_state_t;

	typedef logic [19:0] rwa_word_t;

endpackage : rwa_pkg

/* rtl/rwa_match.sv */
`timescale 1ns/1ps

// Compares one candidate window against the pattern under the length mask.
module rwa_match (
	input  wire logic [31:0] window,
	input  wire logic [31:0] pattern,
	input  wire logic [31:0] mask,
	output logic             hit
);

	// Bits beyond the pattern length are masked out so shorter patterns match.
	assign hit = (((window ^ pattern) & mask) == 32'h0000_0000);

endmodule : rwa_match

/* rtl/rwa_aligner.sv */
// Overview of operation
// - Search received stream for programmed 7/8/10/16/20/32-bit pattern, set boundary there.
// - Manual mode, 16 or 20-bit interface: one alignment after reset without request.
// - Align request is edge-triggered, but level-triggered for a ten-bit interface.
// - Bit-slip mode moves the boundary one bit per rising edge of slip request.
// - Each slip drops the oldest received bit; later words start one bit later.
// - Sync machine mode only with 8B/10B data and ten or twenty-bit width.
// - Sync machine lowers error count by one after N consecutive valid words.
// - Sync machine enters loss of sync after N bad words, N from 1 to 256.
// - Sync declared only after N consecutive patterns, N from 1 to 256.
// - Sync status and pattern-detected outputs are offered to user logic.
// - Sync machine pattern length is 7, 10, or 20 with twenty-bit interface.
// - Run-length check flags when identical contiguous bits exceed threshold 40 to 640.
// - Each edge-triggered align request aligns once; no more until requested again.
//
// Decided for this implementation: register access over APB and the placing of the registers.
`timescale 1ns/1ps
`include "rwa_defs.svh"

module rwa_aligner
	import rwa_pkg::*;
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic [19:0] rx_data_in,
	input  wire logic        rx_valid_in,
	input  wire logic        rx_word_bad,
	output logic      [19:0] rx_data_out,
	output logic             rx_valid_out,
	output logic             rx_syncstatus,
	output logic             rx_patterndetect,
	output logic             rx_rlv,
	output logic             irq
);

	logic [1:0]       mode_reg;
	logic [1:0]       width_reg;
	logic [2:0]       plen_reg;
	logic             enc_reg;
	logic             rl_en_reg;
	logic             align_req_reg;
	logic             slip_req_reg;
	logic [31:0]      pat_reg;
	logic [31:0]      smcfg_reg;
	logic [9:0]       rl_thr_reg;
	logic [4:0]       istat_reg;
	logic [4:0]       imask_reg;
	logic [59:0]      hist_reg;
	logic             proc_v_reg;
	logic [4:0]       off_reg;
	logic             skip_reg;
	logic             align_q_reg;
	logic             slip_q_reg;
	logic             align_pend_reg;
	logic             boot_reg;
	rwa_sync_state_t  state_reg;
	logic [8:0]       err_cnt_reg;
	logic [8:0]       good_cnt_reg;
	logic [8:0]       pat_cnt_reg;
	logic [9:0]       run_reg;
	logic             last_bit_reg;
	logic [9:0]       run_next;
	logic             rl_hit;
	logic [19:0]      match;
	logic             any_match;
	logic [4:0]       first_idx;
	logic [31:0]      pmask;
	logic             sm_legal;
	logic             sm_active;
	logic             level_mode;
	logic             slip_rise;
	logic             setup;
	logic             wr;
	logic             mapped;
	logic [31:0]      rd_mux;
	logic [4:0]       ev;
	logic [4:0]       istat_next;
	logic [8:0]       n_good;
	logic [8:0]       n_bad;
	logic [8:0]       n_pat;

	// Length code to compare mask; shorter patterns match in the low bits.
	function automatic logic [31:0] plen_mask(input logic [2:0] code);
		case (code)
			`RWA_PLEN_7:  plen_mask = 32'h0000_007F;
			`RWA_PLEN_8:  plen_mask = 32'h0000_00FF;
			`RWA_PLEN_10: plen_mask = 32'h0000_03FF;
			`RWA_PLEN_16: plen_mask = 32'h0000_FFFF;
			`RWA_PLEN_20: plen_mask = 32'h000F_FFFF;
			default:      plen_mask = 32'hFFFF_FFFF;
		endcase
	endfunction : plen_mask

	assign pmask      = plen_mask(plen_reg);
	assign level_mode = (width_reg == `RWA_WID_10);
	assign slip_rise  = slip_req_reg & ~slip_q_reg;
	assign n_good     = {1'b0, smcfg_reg[`RWA_GOOD_LSB +: 8]} + 9'h001;
	assign n_bad      = {1'b0, smcfg_reg[`RWA_BAD_LSB +: 8]} + 9'h001;
	assign n_pat      = {1'b0, smcfg_reg[`RWA_NPAT_LSB +: 8]} + 9'h001;

	// The machine is held in loss of sync unless the setup is one it supports.
	assign sm_legal = enc_reg
		& ((width_reg == `RWA_WID_10) | (width_reg == `RWA_WID_20))
		& ((plen_reg == `RWA_PLEN_7) | (plen_reg == `RWA_PLEN_10)
		| ((plen_reg == `RWA_PLEN_20) & (width_reg == `RWA_WID_20)));
	assign sm_active = (mode_reg == `RWA_MODE_SM) & sm_legal;

	// One comparator per candidate boundary; bit 0 of history is the oldest bit.
	for (genvar k = 0; k < `RWA_WORD_W; k++) begin : g_cmp
		rwa_match u_match (
			.window  (hist_reg[k +: 32]),
			.pattern (pat_reg),
			.mask    (pmask),
			.hit     (match[k])
		);
	end

	// The lowest matching offset wins, i.e. the earliest pattern in the stream.
	always_comb begin
		any_match = |match;
		first_idx = 5'h00;
		for (int i = `RWA_WORD_W - 1; i >= 0; i--) begin
			if (match[i]) begin
				first_idx = i[4:0];
			end
		end
	end

	// Contiguous identical bits, counted across word edges in arrival order.
	always_comb begin
		logic lb;
		lb       = last_bit_reg;
		run_next = run_reg;
		rl_hit   = 1'b0;
		for (int i = 0; i < `RWA_WORD_W; i++) begin
			if (rx_data_in[i] == lb) begin
				run_next = (run_next == 10'h3FF) ? run_next : run_next + 10'h001;
			end else begin
				run_next = 10'h001;
			end
			lb = rx_data_in[i];
			if (run_next > rl_thr_reg) begin
				rl_hit = rl_en_reg & rx_valid_in;
			end
		end
	end

	// Stream history; a new word enters at the top and the oldest falls out.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hist_reg     <= 60'h0;
			proc_v_reg   <= 1'b0;
			run_reg      <= 10'h000;
			last_bit_reg <= 1'b0;
		end else begin
			proc_v_reg <= rx_valid_in;
			if (rx_valid_in) begin
				hist_reg     <= {rx_data_in, hist_reg[59:20]};
				run_reg      <= run_next;
				last_bit_reg <= rx_data_in[19];
			end
		end
	end

	// Manual request tracking: edge arms one alignment, level keeps it armed.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			align_q_reg    <= 1'b0;
			slip_q_reg     <= 1'b0;
			align_pend_reg <= 1'b0;
			boot_reg       <= 1'b1;
		end else begin
			align_q_reg <= align_req_reg;
			slip_q_reg  <= slip_req_reg;
			boot_reg    <= 1'b0;
			if (mode_reg != `RWA_MODE_MANUAL) begin
				align_pend_reg <= 1'b0;
			end else if ((boot_reg
				& ((width_reg == `RWA_WID_16) | (width_reg == `RWA_WID_20)))
				| (level_mode ? align_req_reg : (align_req_reg & ~align_q_reg))) begin
				align_pend_reg <= 1'b1;
			end else if (proc_v_reg & any_match) begin
				align_pend_reg <= 1'b0;
			end
		end
	end

	// Boundary offset: set by a found pattern or stepped by a slip request.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			off_reg  <= 5'h00;
			skip_reg <= 1'b0;
		end else begin
			if ((mode_reg == `RWA_MODE_SLIP) & slip_rise) begin
				if (off_reg == `RWA_OFF_MAX) begin
					// Wrapping to the next word's first bit is a one-bit step only if
					// the word now straddled is dropped from the output.
					off_reg  <= 5'h00;
					skip_reg <= 1'b1;
				end else begin
					off_reg <= off_reg + 5'h01;
				end
			end else if (proc_v_reg & any_match
				& (((mode_reg == `RWA_MODE_MANUAL) & align_pend_reg)
				| (sm_active & (state_reg == ST_LOSS)))) begin
				off_reg <= first_idx;
			end
			if (proc_v_reg & skip_reg & ~((mode_reg == `RWA_MODE_SLIP) & slip_rise)) begin
				skip_reg <= 1'b0;
			end
		end
	end

	// Aligned output word and pattern-detected pulse.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_data_out      <= 20'h0_0000;
			rx_valid_out     <= 1'b0;
			rx_patterndetect <= 1'b0;
		end else begin
			rx_valid_out     <= proc_v_reg & ~skip_reg;
			rx_patterndetect <= proc_v_reg & ~skip_reg & match[off_reg];
			if (proc_v_reg & ~skip_reg) begin
				rx_data_out <= hist_reg[off_reg +: 20];
			end
		end
	end

	// Synchronization machine with good-word credit against the error count.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg    <= ST_LOSS;
			err_cnt_reg  <= 9'h000;
			good_cnt_reg <= 9'h000;
			pat_cnt_reg  <= 9'h000;
		end else if (!sm_active) begin
			state_reg    <= ST_LOSS;
			err_cnt_reg  <= 9'h000;
			good_cnt_reg <= 9'h000;
			pat_cnt_reg  <= 9'h000;
		end else if (proc_v_reg) begin
			unique case (state_reg)
				ST_LOSS: begin
					if (any_match) begin
						pat_cnt_reg <= 9'h001;
						state_reg   <= (n_pat == 9'h001) ? ST_SYNC : ST_ACQ;
						err_cnt_reg <= 9'h000;
						good_cnt_reg <= 9'h000;
					end
				end
				ST_ACQ: begin
					if (rx_word_bad) begin
						state_reg   <= ST_LOSS;
						pat_cnt_reg <= 9'h000;
					end else if (match[off_reg]) begin
						pat_cnt_reg <= pat_cnt_reg + 9'h001;
						if (pat_cnt_reg + 9'h001 == n_pat) begin
							state_reg <= ST_SYNC;
						end
					end
				end
				ST_SYNC: begin
					if (rx_word_bad) begin
						good_cnt_reg <= 9'h000;
						if (err_cnt_reg + 9'h001 == n_bad) begin
							state_reg   <= ST_LOSS;
							err_cnt_reg <= 9'h000;
						end else begin
							err_cnt_reg <= err_cnt_reg + 9'h001;
						end
					end else if (good_cnt_reg + 9'h001 == n_good) begin
						good_cnt_reg <= 9'h000;
						if (err_cnt_reg != 9'h000) begin
							err_cnt_reg <= err_cnt_reg - 9'h001;
						end
					end else begin
						good_cnt_reg <= good_cnt_reg + 9'h001;
					end
				end
			endcase
		end
	end

	// Status follows the state one cycle later, so it is low out of reset until a cycle after ST_SYNC.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_syncstatus <= 1'b0;
			rx_rlv        <= 1'b0;
		end else begin
			rx_syncstatus <= (state_reg == ST_SYNC);
			rx_rlv        <= rl_hit;
		end
	end

	// Events for the sticky status; a set in the clearing cycle survives.
	assign ev[`RWA_IRQ_PAT]  = proc_v_reg & ~skip_reg & match[off_reg];
	assign ev[`RWA_IRQ_SYNC] = (state_reg == ST_SYNC) & ~rx_syncstatus;
	assign ev[`RWA_IRQ_LOSS] = (state_reg != ST_SYNC) & rx_syncstatus;
	assign ev[`RWA_IRQ_RLV]  = rl_hit;
	assign ev[`RWA_IRQ_CFG]  = (mode_reg == `RWA_MODE_SM) & ~sm_legal;

	// APB: registered zero-wait answer, so pready rises in the access phase.
	assign setup  = psel & ~penable;
	assign wr     = psel & penable & pready & pwrite & ~pslverr;
	assign mapped = (paddr == `RWA_CTRL_OFF) | (paddr == `RWA_PAT_OFF)
		| (paddr == `RWA_SMCFG_OFF) | (paddr == `RWA_RLCFG_OFF)
		| (paddr == `RWA_STATUS_OFF) | (paddr == `RWA_ISTAT_OFF)
		| (paddr == `RWA_IMASK_OFF);
	assign istat_next = (istat_reg
		& ~((wr & (paddr == `RWA_ISTAT_OFF)) ? pwdata[4:0] : 5'h00)) | ev;

	// Read data; reserved bits read as zero.
	always_comb begin
		unique case (paddr)
			`RWA_CTRL_OFF:   rd_mux = {21'h0, slip_req_reg, align_req_reg, rl_en_reg,
				enc_reg, plen_reg, width_reg, mode_reg};
			`RWA_PAT_OFF:    rd_mux = pat_reg;
			`RWA_SMCFG_OFF:  rd_mux = smcfg_reg;
			`RWA_RLCFG_OFF:  rd_mux = {22'h0, rl_thr_reg};
			`RWA_STATUS_OFF: rd_mux = {15'h0, err_cnt_reg, state_reg, rx_syncstatus, off_reg};
			`RWA_ISTAT_OFF:  rd_mux = {27'h0, istat_reg};
			`RWA_IMASK_OFF:  rd_mux = {27'h0, imask_reg};
			default:         rd_mux = 32'h0000_0000;
		endcase
	end

	// Bus handshake and read capture.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end else begin
			pready  <= setup;
			pslverr <= setup & ~mapped;
			if (setup) begin
				prdata <= rd_mux;
			end
		end
	end

	// Software-written registers.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode_reg      <= 2'(`RWA_CTRL_RST >> `RWA_MODE_LSB);
			width_reg     <= 2'(`RWA_CTRL_RST >> `RWA_WIDTH_LSB);
			plen_reg      <= 3'(`RWA_CTRL_RST >> `RWA_PLEN_LSB);
			enc_reg       <= 1'(`RWA_CTRL_RST >> `RWA_ENC_BIT);
			rl_en_reg     <= 1'(`RWA_CTRL_RST >> `RWA_RLEN_BIT);
			align_req_reg <= 1'b0;
			slip_req_reg  <= 1'b0;
			pat_reg       <= `RWA_PAT_RST;
			smcfg_reg     <= `RWA_SMCFG_RST;
			rl_thr_reg    <= 10'(`RWA_RLCFG_RST);
			imask_reg     <= 5'h00;
		end else if (wr) begin
			if (paddr == `RWA_CTRL_OFF) begin
				mode_reg      <= pwdata[`RWA_MODE_LSB +: 2];
				width_reg     <= pwdata[`RWA_WIDTH_LSB +: 2];
				plen_reg      <= pwdata[`RWA_PLEN_LSB +: 3];
				enc_reg       <= pwdata[`RWA_ENC_BIT];
				rl_en_reg     <= pwdata[`RWA_RLEN_BIT];
				align_req_reg <= pwdata[`RWA_ALIGN_BIT];
				slip_req_reg  <= pwdata[`RWA_SLIP_BIT];
			end
			if (paddr == `RWA_PAT_OFF) begin
				pat_reg <= pwdata;
			end
			if (paddr == `RWA_SMCFG_OFF) begin
				smcfg_reg <= {8'h00, pwdata[23:0]};
			end
			if (paddr == `RWA_RLCFG_OFF) begin
				rl_thr_reg <= pwdata[9:0];
			end
			if (paddr == `RWA_IMASK_OFF) begin
				imask_reg <= pwdata[4:0];
			end
		end
	end

	// Sticky interrupt status and the masked level output.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			istat_reg <= 5'h00;
			irq       <= 1'b0;
		end else begin
			istat_reg <= istat_next;
			irq       <= |(istat_next & imask_reg);
		end
	end

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence slip_step_s;
		(mode_reg == `RWA_MODE_SLIP) && slip_rise && (off_reg != `RWA_OFF_MAX);
	endsequence

	sequence sync_bad_last_s;
		sm_active && proc_v_reg && (state_reg == ST_SYNC) && rx_word_bad
			&& (err_cnt_reg + 9'h001 == n_bad);
	endsequence

	slip_one_bit_a: assert property (slip_step_s |=> off_reg == $past(off_reg) + 5'h01)
		else $error("bit slip did not advance boundary by one");

	slip_wrap_skip_a: assert property ((mode_reg == `RWA_MODE_SLIP) && slip_rise
		&& (off_reg == `RWA_OFF_MAX) |=> (off_reg == 5'h00) && skip_reg)
		else $error("slip wrap did not drop a word");

	loss_after_bad_a: assert property (sync_bad_last_s |=> (state_reg == ST_LOSS)
		##1 !rx_syncstatus)
		else $error("loss of sync not entered after bad words");

	sync_after_pats_a: assert property (sm_active && proc_v_reg && (state_reg == ST_ACQ)
		&& !rx_word_bad && match[off_reg] && (pat_cnt_reg + 9'h001 == n_pat)
		|=> (state_reg == ST_SYNC) ##1 rx_syncstatus)
		else $error("sync not declared after pattern count");

	err_credit_a: assert property (sm_active && proc_v_reg && (state_reg == ST_SYNC)
		&& !rx_word_bad && (good_cnt_reg + 9'h001 == n_good) && (err_cnt_reg != 9'h000)
		|=> err_cnt_reg == $past(err_cnt_reg) - 9'h001)
		else $error("error count not reduced after valid words");

	sm_gate_a: assert property (!sm_active |=> state_reg == ST_LOSS)
		else $error("sync machine ran in an unsupported setup");

	sync_status_a: assert property (rx_syncstatus == $past(state_reg == ST_SYNC))
		else $error("sync status does not follow the state");

	patdet_cause_a: assert property (rx_patterndetect
		|-> $past(proc_v_reg && !skip_reg && match[off_reg]))
		else $error("pattern detect without a match at boundary");

	manual_once_a: assert property ((mode_reg == `RWA_MODE_MANUAL) && align_pend_reg
		&& proc_v_reg && any_match && !boot_reg
		&& !(align_req_reg && (level_mode || !align_q_reg))
		|=> !align_pend_reg && (off_reg == $past(first_idx)))
		else $error("manual alignment not taken exactly once");

	rl_flag_a: assert property (rl_hit |=> rx_rlv && istat_reg[`RWA_IRQ_RLV])
		else $error("run length violation not flagged");

endmodule : rwa_aligner

/* verif/rwa_tx_model.sv */
`timescale 1ns/1ps

// Far transmitter seen through the deserializer, plus the decoder's bad-word verdict.
module rwa_tx_model
	import rwa_pkg::*;
(
	input  wire logic       pclk,
	input  wire logic       presetn,
	input  wire logic       run,
	input  wire logic [4:0] shift,
	input  wire logic       bad,
	output rwa_word_t       rx_data_in,
	output logic            rx_valid_in,
	output logic            rx_word_bad
);
	logic bad_q;

	// One word per clock; a pause inverts the bus so a stale word never passes for a fresh one.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_data_in  <= 20'h0_0000;
			rx_valid_in <= 1'b0;
			bad_q       <= 1'b0;
		end else if (run) begin
			rx_data_in  <= 20'h0_017C << shift;
			rx_valid_in <= 1'b1;
			bad_q       <= bad;
		end else begin
			rx_data_in  <= ~rx_data_in;
			rx_valid_in <= 1'b0;
			bad_q       <= 1'b0;
		end
	end

	// The verdict trails its word by one cycle, as a real decoder would.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_word_bad <= 1'b0;
		end else begin
			rx_word_bad <= bad_q;
		end
	end
endmodule : rwa_tx_model

/* verif/tb.sv */
`timescale 1ns/1ps
`include "rwa_defs.svh"

module tb
	import rwa_pkg::*;
;
	localparam logic [31:0] ENC = 32'h0000_0080;
	localparam logic [31:0] RLE = 32'h0000_0100;
	localparam logic [31:0] ALN = 32'h0000_0200;
	localparam logic [31:0] SLP = 32'h0000_0400;
	localparam logic [31:0] ALL = 32'hFFFF_FFFF;
	localparam logic [7:0]  CT  = `RWA_CTRL_OFF;
	localparam logic [7:0]  ST  = `RWA_STATUS_OFF;
	localparam logic [7:0]  IS  = `RWA_ISTAT_OFF;

	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [19:0] rx_data_in, rx_data_out;
	logic        rx_valid_in, rx_word_bad, rx_valid_out, rx_syncstatus;
	logic        rx_patterndetect, rx_rlv, irq, run, bad;
	logic [4:0]  shift;
	int          miscompares, num_checks;

	rwa_aligner rwa_aligner_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .rx_data_in(rx_data_in),
		.rx_valid_in(rx_valid_in), .rx_word_bad(rx_word_bad), .rx_data_out(rx_data_out),
		.rx_valid_out(rx_valid_out), .rx_syncstatus(rx_syncstatus),
		.rx_patterndetect(rx_patterndetect), .rx_rlv(rx_rlv), .irq(irq));

	rwa_tx_model rwa_tx_model_inst (.pclk(pclk), .presetn(presetn), .run(run),
		.shift(shift), .bad(bad), .rx_data_in(rx_data_in), .rx_valid_in(rx_valid_in),
		.rx_word_bad(rx_word_bad));

	// Free-running bus clock.
	initial begin
		pclk = 1'b0;
		forever #10 pclk = ~pclk;
	end

	task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk_val

	// One APB transfer; the request is held until pready is seen high at an edge.
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel   <= 1'b1;
		pwrite <= wr;
		paddr  <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) miscompares++;
		rd = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask : wr

	task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		apb(1'b0, a, 32'h0000_0000);
		chk_val(rd & m, e);
	endtask : rdc

	function automatic logic [31:0] mk(input logic [1:0] m, input logic [1:0] w,
		input logic [2:0] p);
		mk = 32'(m) | (32'(w) << `RWA_WIDTH_LSB) | (32'(p) << `RWA_PLEN_LSB);
	endfunction : mk

	// A counted burst of words, all bad or all good, then a pause to drain the pipeline.
	task automatic burst(input int k, input logic b);
		@(posedge pclk);
		run <= 1'b1;
		bad <= b;
		repeat (k) @(posedge pclk);
		run <= 1'b0;
		bad <= 1'b0;
		repeat (8) @(posedge pclk);
	endtask : burst

	task automatic t_regs;
		logic [31:0] r;
		r = `RWA_CTRL_RST;
		rdc(CT, ALL, `RWA_CTRL_RST);
		rdc(`RWA_PAT_OFF, ALL, `RWA_PAT_RST);
		rdc(`RWA_SMCFG_OFF, ALL, `RWA_SMCFG_RST);
		rdc(`RWA_RLCFG_OFF, ALL, `RWA_RLCFG_RST);
		rdc(`RWA_IMASK_OFF, ALL, 32'h0000_0000);
		wr(8'h1C, ALL);
		chk_val(32'(err), 32'h0000_0001);
		rdc(8'h1C, ALL, 32'h0000_0000);
		chk_val(32'(err), 32'h0000_0001);
		// The start-up alignment only applies to a manual 16 or 20 bit reset setup.
		if (r[1:0] == `RWA_MODE_MANUAL && r[3] && r[6:4] == `RWA_PLEN_10) begin
			rdc(ST, 32'h0000_001F, 32'h0000_0003);
		end
	endtask : t_regs

	task automatic t_manual;
		logic [31:0] c;
		c = mk(`RWA_MODE_MANUAL, `RWA_WID_20, `RWA_PLEN_10) | ENC;
		// A new phase first, so that only the request itself can move the boundary.
		shift <= 5'd4;
		wr(CT, c);
		wr(CT, c | ALN);
		repeat (10) @(posedge pclk);
		rdc(ST, 32'h0000_001F, 32'h0000_0004);
		chk_val({12'h000, rx_data_out}, 32'h0000_017C);
		chk_val(32'(rx_valid_out), 32'h0000_0001);
		chk_val(32'(rx_patterndetect), 32'h0000_0001);
		rdc(IS, 32'h0000_0001, 32'h0000_0001);
		shift <= 5'd5;
		repeat (10) @(posedge pclk);
		rdc(ST, 32'h0000_001F, 32'h0000_0004);
		wr(CT, c);
		wr(CT, c | ALN);
		repeat (10) @(posedge pclk);
		rdc(ST, 32'h0000_001F, 32'h0000_0005);
		shift <= 5'd7;
		repeat (10) @(posedge pclk);
		rdc(ST, 32'h0000_001F, 32'h0000_0005);
		wr(CT, mk(`RWA_MODE_MANUAL, `RWA_WID_10, `RWA_PLEN_10) | ENC | ALN);
		repeat (10) @(posedge pclk);
		rdc(ST, 32'h0000_001F, 32'h0000_0007);
		shift <= 5'd6;
		repeat (10) @(posedge pclk);
		rdc(ST, 32'h0000_001F, 32'h0000_0006);
	endtask : t_manual

	task automatic t_slip;
		logic [31:0] c;
		c = mk(`RWA_MODE_SLIP, `RWA_WID_20, `RWA_PLEN_10) | ENC;
		// Stepping on past offset nineteen wraps to the next word's first bit.
		for (int i = 7; i < 21; i++) begin
			wr(CT, c);
			wr(CT, c | SLP);
			repeat (10) @(posedge pclk);
			rdc(ST, 32'h0000_001F, 32'(i % 20));
			chk_val({12'h000, rx_data_out},
				32'((40'h05_F000_5F00 >> (i % 20)) & 40'h00_000F_FFFF));
		end
	endtask : t_slip

	// Illegal machine setups raise the config flag, which drives irq while unmasked.
	task automatic t_cfg;
		logic [31:0] bad_cfg [4];
		bad_cfg = '{mk(`RWA_MODE_SM, `RWA_WID_20, `RWA_PLEN_10),
			mk(`RWA_MODE_SM, `RWA_WID_8, `RWA_PLEN_10) | ENC,
			mk(`RWA_MODE_SM, `RWA_WID_20, `RWA_PLEN_8) | ENC,
			mk(`RWA_MODE_SM, `RWA_WID_10, `RWA_PLEN_20) | ENC};
		wr(`RWA_IMASK_OFF, 32'h0000_0010);
		foreach (bad_cfg[i]) begin
			wr(CT, mk(`RWA_MODE_SM, `RWA_WID_10, `RWA_PLEN_7) | ENC);
			wr(IS, 32'h0000_0010);
			rdc(IS, 32'h0000_0010, 32'h0000_0000);
			chk_val(32'(irq), 32'h0000_0000);
			wr(CT, bad_cfg[i]);
			rdc(IS, 32'h0000_0010, 32'h0000_0010);
			chk_val(32'(irq), 32'h0000_0001);
		end
		wr(`RWA_IMASK_OFF, 32'h0000_0000);
		rdc(`RWA_IMASK_OFF, ALL, 32'h0000_0000);
		chk_val(32'(irq), 32'h0000_0000);
	endtask : t_cfg

	task automatic t_sync;
		int n;
		n = 0;
		wr(CT, mk(`RWA_MODE_SM, `RWA_WID_20, `RWA_PLEN_10) | ENC);
		while (rx_syncstatus !== 1'b1 && n < 40) begin
			@(posedge pclk);
			n++;
		end
		chk_val(32'(rx_syncstatus), 32'h0000_0001);
		run <= 1'b0;
		burst(3, 1'b1);
		rdc(ST, 32'h0001_FFE0, 32'h0000_03A0);
		burst(4, 1'b0);
		rdc(ST, 32'h0001_FFE0, 32'h0000_02A0);
		burst(1, 1'b1);
		rdc(ST, 32'h0001_FFE0, 32'h0000_03A0);
		burst(1, 1'b1);
		rdc(ST, 32'h0000_00E0, 32'h0000_0000);
		chk_val(32'(rx_syncstatus), 32'h0000_0000);
		rdc(IS, 32'h0000_0006, 32'h0000_0006);
	endtask : t_sync

	// The model's longest run is thirteen zeros, so the flag sits exactly at that threshold.
	task automatic t_rlen;
		wr(CT, mk(`RWA_MODE_MANUAL, `RWA_WID_20, `RWA_PLEN_10) | ENC | RLE);
		run <= 1'b1;
		wr(`RWA_RLCFG_OFF, 32'h0000_000D);
		repeat (4) @(posedge pclk);
		wr(IS, 32'h0000_0008);
		repeat (10) @(posedge pclk);
		rdc(IS, 32'h0000_0008, 32'h0000_0000);
		chk_val(32'(rx_rlv), 32'h0000_0000);
		wr(`RWA_RLCFG_OFF, 32'h0000_000C);
		repeat (10) @(posedge pclk);
		rdc(IS, 32'h0000_0008, 32'h0000_0008);
		chk_val(32'(rx_rlv), 32'h0000_0001);
	endtask : t_rlen

	task automatic wrap_up;
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : wrap_up

	// A hang is cut short well past the few hundred cycles the run needs.
	initial begin
		repeat (20000) @(posedge pclk);
		miscompares++;
		wrap_up();
	end

	// Main sequence.
	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		run = 1'b0;
		bad = 1'b0;
		shift = 5'd3;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		run <= 1'b1;
		t_regs();
		t_manual();
		t_slip();
		t_cfg();
		t_sync();
		t_rlen();
		wrap_up();
	end
endmodule : tb
